// File: common/ldact_pkg.sv
// constants, register map and types for the led gauge display activation block
// Summary of operation
// - display starts from host command, reset exit, charge activity or request pin falling edge
// - host command written over the register bus activates the display
// - with reset display enable set, display activates on leaving reset
// - with charge display enable set, display stays active while current exceeds threshold
// - a high-to-low transition on the request pin activates the capacity display
// - further request pin falling edges ignored until the display hold time expires
// - request held low for long press time adds failure display after capacity display
// - pack voltage at or below terminate voltage disables the display, overriding all
// - failure display enable shows failure display afterwards for twice the hold time
// - trigger select 0: failure display only after long press on the request pin
// - trigger select 1: any request pin falling edge triggers the failure display
// - default discharge thresholds for fourth and fifth lamps are 60 and 80 percent
// - lamps light one after another with the step delay between them
// - after all lamps lit, hold for display hold time, then all off together
package ldact_pkg;
  // ****************************************************************
  // register map (byte addresses)
  // ****************************************************************
  localparam logic [7:0] LDACT_ADDR_CTRL    = 8'h00;
  localparam logic [7:0] LDACT_ADDR_CMD     = 8'h04;
  localparam logic [7:0] LDACT_ADDR_CURR    = 8'h08;
  localparam logic [7:0] LDACT_ADDR_VOLT    = 8'h0C;
  localparam logic [7:0] LDACT_ADDR_THRESH  = 8'h10;
  localparam logic [7:0] LDACT_ADDR_STATUS  = 8'h14;
  // ctrl field positions
  localparam int LDACT_CTRL_RSTDISP = 0;
  localparam int LDACT_CTRL_CHGDISP = 1;
  localparam int LDACT_CTRL_FAILEN  = 2;
  localparam int LDACT_CTRL_FAILSEL = 3;
  localparam int LDACT_CMD_START    = 0;
  localparam logic [3:0]  LDACT_CTRL_RESET   = 4'h1; // reset display on, so leaving reset lights the gauge
  localparam logic [15:0] LDACT_CURR_RESET   = 16'h0000;
  localparam logic [15:0] LDACT_VOLT_RESET   = 16'hFFFF;
  // default discharge thresholds, percent
  localparam logic [7:0]  LDACT_LAMP4_OFF_DEF = 8'h3C; // 60 percent
  localparam logic [7:0]  LDACT_LAMP5_OFF_DEF = 8'h50; // 80 percent
  localparam logic [15:0] LDACT_CHG_CURR_DEF  = 16'h0064;
  localparam logic [15:0] LDACT_TERM_VOLT_DEF = 16'h2328;
  localparam logic [1:0]  LDACT_RESP_OKAY     = 2'h0;
  localparam logic [1:0]  LDACT_RESP_SLVERR   = 2'h2;
  // ****************************************************************
  // timing
  // ****************************************************************
  localparam longint LDACT_CLK_HZ       = 250000000;
  localparam longint LDACT_HOLD_S       = 4;   // display hold time, s
  localparam longint LDACT_LONGPRESS_MS = 1000; // long press time, ms
  localparam longint LDACT_STEP_MS      = 50;  // lamp step delay, ms
  localparam longint LDACT_HOLD_CYC     = LDACT_HOLD_S * LDACT_CLK_HZ;
  localparam longint LDACT_LONGPRESS_CYC = (LDACT_LONGPRESS_MS * LDACT_CLK_HZ + 999) / 1000;
  localparam longint LDACT_STEP_CYC     = (LDACT_STEP_MS * LDACT_CLK_HZ + 999) / 1000;
  localparam int     LDACT_FAIL_MULT    = 2;
  localparam int     LDACT_NUM_LAMPS    = 5;
  // ****************************************************************
  // display states, gray coded along the usual path
  // ****************************************************************
  typedef enum logic [1:0] {
    LDACT_IDLE = 2'h0,
    LDACT_STEP = 2'h1,
    LDACT_HOLD = 2'h3,
    LDACT_FAIL = 2'h2
  } ldact_state_t;
endpackage : ldact_pkg

// File: common/ldact_cfg_if.sv
// interface carrying configuration and commands from the register file to the display core
`timescale 1ns/1ps
interface ldact_cfg_if;
  logic        rstDispEn;
  logic        chgDispEn;
  logic        failDispEn;
  logic        failTrigSel;
  logic        hostStart;
  logic [15:0] packCurrent;
  logic [15:0] packVoltage;
  logic [15:0] chgDetectCurrent;
  logic [15:0] termVoltage;
  logic [1:0]  dispState;
  logic        dispActive;
  logic        lockout;
  modport regs (output rstDispEn, chgDispEn, failDispEn, failTrigSel, hostStart, packCurrent,
                packVoltage, chgDetectCurrent, termVoltage, input dispState, dispActive, lockout);
  modport core (input rstDispEn, chgDispEn, failDispEn, failTrigSel, hostStart, packCurrent,
                packVoltage, chgDetectCurrent, termVoltage, output dispState, dispActive, lockout);
endinterface : ldact_cfg_if

// File: verilog/ldact_req_sync.sv
// request pin synchroniser with falling edge and long press detection
`timescale 1ns/1ps
module ldact_req_sync #(
  parameter longint LONG_CYC = ldact_pkg::LDACT_LONGPRESS_CYC
) (
  // clock and reset
  input  wire logic clock,
  input  wire logic rst_b,
  // pin and events
  input  wire logic reqPin,
  output logic      fallPulse,
  output logic      longPulse
);
  import ldact_pkg::*;
  logic        meta_r;
  logic        sync_r;
  logic        prev_r;
  logic [31:0] lowCnt_r;
  logic        longDone_r;
  wire         atLong = (lowCnt_r == 32'(LONG_CYC - 1));
  // two flop synchroniser and edge history
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      meta_r <= 1'b1;
      sync_r <= 1'b1;
      prev_r <= 1'b1;
    end else begin
      meta_r <= reqPin;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end
  assign fallPulse = prev_r & ~sync_r;
  assign longPulse = ~sync_r & atLong & ~longDone_r;
  // low level duration counter
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      lowCnt_r   <= 32'h0000_0000;
      longDone_r <= 1'b0;
    end else if (sync_r) begin
      lowCnt_r   <= 32'h0000_0000;
      longDone_r <= 1'b0;
    end else if (atLong) begin
      longDone_r <= 1'b1;
    end else begin
      lowCnt_r <= lowCnt_r + 32'h0000_0001;
    end
  end
endmodule : ldact_req_sync

// File: verilog/ldact_regs.sv
// axi4-lite register file for the display activation block
`timescale 1ns/1ps
module ldact_regs (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rst_b,
  // axi4-lite slave
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // core side
  ldact_cfg_if.regs        cfg
);
  import ldact_pkg::*;
  logic [3:0]  ctrl_r;
  logic [15:0] curr_r;
  logic [15:0] volt_r;
  logic [15:0] chgThr_r;
  logic [15:0] termV_r;
  logic        start_r;
  logic        awGot_r;
  logic        wGot_r;
  logic [7:0]  awAddr_r;
  logic [31:0] wData_r;
  logic [3:0]  wStrb_r;
  // write side: take address and data in any order
  assign awready = ~awGot_r & ~bvalid;
  assign wready  = ~wGot_r & ~bvalid;
  wire doWrite = awGot_r & wGot_r & ~bvalid;
  wire wLo     = wStrb_r[0];
  wire wHi     = wStrb_r[1];
  wire wrCtrl  = doWrite & (awAddr_r == LDACT_ADDR_CTRL);
  wire wrCmd   = doWrite & (awAddr_r == LDACT_ADDR_CMD);
  wire wrCurr  = doWrite & (awAddr_r == LDACT_ADDR_CURR);
  wire wrVolt  = doWrite & (awAddr_r == LDACT_ADDR_VOLT);
  wire wrThr   = doWrite & (awAddr_r == LDACT_ADDR_THRESH);
  wire wrOk    = wrCtrl | wrCmd | wrCurr | wrVolt | wrThr;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      awGot_r  <= 1'b0;
      wGot_r   <= 1'b0;
      awAddr_r <= 8'h00;
      wData_r  <= 32'h0000_0000;
      wStrb_r  <= 4'h0;
      bvalid   <= 1'b0;
      bresp    <= LDACT_RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        awGot_r  <= 1'b1;
        awAddr_r <= awaddr;
      end
      if (wvalid && wready) begin
        wGot_r  <= 1'b1;
        wData_r <= wdata;
        wStrb_r <= wstrb;
      end
      if (doWrite) begin
        awGot_r <= 1'b0;
        wGot_r  <= 1'b0;
        bvalid  <= 1'b1;
        bresp   <= wrOk ? LDACT_RESP_OKAY : LDACT_RESP_SLVERR;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end
  // register storage; the command register is a self clearing start pulse
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_r   <= LDACT_CTRL_RESET;
      curr_r   <= LDACT_CURR_RESET;
      volt_r   <= LDACT_VOLT_RESET;
      chgThr_r <= LDACT_CHG_CURR_DEF;
      termV_r  <= LDACT_TERM_VOLT_DEF;
      start_r  <= 1'b0;
    end else begin
      start_r <= wrCmd & wLo & wData_r[LDACT_CMD_START];
      if (wrCtrl && wLo) ctrl_r <= wData_r[3:0];
      if (wrCurr && wLo) curr_r[7:0] <= wData_r[7:0];
      if (wrCurr && wHi) curr_r[15:8] <= wData_r[15:8];
      if (wrVolt && wLo) volt_r[7:0] <= wData_r[7:0];
      if (wrVolt && wHi) volt_r[15:8] <= wData_r[15:8];
      if (wrThr && wLo) chgThr_r[7:0] <= wData_r[7:0];
      if (wrThr && wHi) chgThr_r[15:8] <= wData_r[15:8];
      if (wrThr && wStrb_r[2]) termV_r[7:0] <= wData_r[23:16];
      if (wrThr && wStrb_r[3]) termV_r[15:8] <= wData_r[31:24];
    end
  end
  assign cfg.rstDispEn        = ctrl_r[LDACT_CTRL_RSTDISP];
  assign cfg.chgDispEn        = ctrl_r[LDACT_CTRL_CHGDISP];
  assign cfg.failDispEn       = ctrl_r[LDACT_CTRL_FAILEN];
  assign cfg.failTrigSel      = ctrl_r[LDACT_CTRL_FAILSEL];
  assign cfg.hostStart        = start_r;
  assign cfg.packCurrent      = curr_r;
  assign cfg.packVoltage      = volt_r;
  assign cfg.chgDetectCurrent = chgThr_r;
  assign cfg.termVoltage      = termV_r;
  // read side
  assign arready = ~rvalid;
  wire [31:0] statusWord = {28'h0000000, cfg.lockout, cfg.dispActive, cfg.dispState};
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rvalid <= 1'b0;
      rdata  <= 32'h0000_0000;
      rresp  <= LDACT_RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rresp  <= LDACT_RESP_OKAY;
      case (araddr)
        LDACT_ADDR_CTRL:   rdata <= {28'h0000000, ctrl_r};
        LDACT_ADDR_CMD:    rdata <= 32'h0000_0000;
        LDACT_ADDR_CURR:   rdata <= {16'h0000, curr_r};
        LDACT_ADDR_VOLT:   rdata <= {16'h0000, volt_r};
        LDACT_ADDR_THRESH: rdata <= {termV_r, chgThr_r};
        LDACT_ADDR_STATUS: rdata <= statusWord;
        default: begin
          rdata <= 32'h0000_0000;
          rresp <= LDACT_RESP_SLVERR;
        end
      endcase
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
    end
  end
endmodule : ldact_regs

// File: verilog/ldact_display.sv
// top of the led gauge display activation block: sources, lockout, sequencing
`timescale 1ns/1ps
module ldact_display #(
  parameter longint HOLD_CYC  = ldact_pkg::LDACT_HOLD_CYC,
  parameter longint STEP_CYC  = ldact_pkg::LDACT_STEP_CYC,
  parameter longint LONG_CYC  = ldact_pkg::LDACT_LONGPRESS_CYC,
  parameter int     NUM_LAMPS = ldact_pkg::LDACT_NUM_LAMPS
) (
  // clock and reset
  input  wire logic                 clock,
  input  wire logic                 rst_b,
  // axi4-lite slave
  input  wire logic [7:0]           awaddr,
  input  wire logic                 awvalid,
  output logic                      awready,
  input  wire logic [31:0]          wdata,
  input  wire logic [3:0]           wstrb,
  input  wire logic                 wvalid,
  output logic                      wready,
  output logic [1:0]                bresp,
  output logic                      bvalid,
  input  wire logic                 bready,
  input  wire logic [7:0]           araddr,
  input  wire logic                 arvalid,
  output logic                      arready,
  output logic [31:0]               rdata,
  output logic [1:0]                rresp,
  output logic                      rvalid,
  input  wire logic                 rready,
  // display request pin, active low press
  input  wire logic                 displayRequestPin,
  // lamp count to light, from the capacity mapper
  input  wire logic [2:0]           activeLamps,
  // lamp segment drivers
  output logic [NUM_LAMPS-1:0]      lampOn,
  output logic                      failDisplayOn,
  // default discharge thresholds for lamps four and five
  output logic [7:0]                fourthLampDischargeThreshold,
  output logic [7:0]                fifthLampDischargeThreshold
);
  import ldact_pkg::*;
  // ****************************************************************
  // submodules
  // ****************************************************************
  ldact_cfg_if cfg ();
  logic fallPulse;
  logic longPulse;
  ldact_regs uRegs (
    .clock   (clock),
    .rst_b   (rst_b),
    .awaddr  (awaddr),
    .awvalid (awvalid),
    .awready (awready),
    .wdata   (wdata),
    .wstrb   (wstrb),
    .wvalid  (wvalid),
    .wready  (wready),
    .bresp   (bresp),
    .bvalid  (bvalid),
    .bready  (bready),
    .araddr  (araddr),
    .arvalid (arvalid),
    .arready (arready),
    .rdata   (rdata),
    .rresp   (rresp),
    .rvalid  (rvalid),
    .rready  (rready),
    .cfg     (cfg)
  );
  ldact_req_sync #(.LONG_CYC(LONG_CYC)) uSync (
    .clock     (clock),
    .rst_b     (rst_b),
    .reqPin    (displayRequestPin),
    .fallPulse (fallPulse),
    .longPulse (longPulse)
  );
  // ****************************************************************
  // activation sources
  // ****************************************************************
  ldact_state_t state_r;
  ldact_state_t state_nxt;
  logic [31:0]  timer_r;
  logic [2:0]   litCnt_r;
  logic         lock_r;
  logic         failPend_r;
  logic         resetSeen_r;
  logic         rstStart_r;
  // reset exit start fires once, on the first cycle after release
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      resetSeen_r <= 1'b0;
      rstStart_r  <= 1'b0;
    end else begin
      resetSeen_r <= 1'b1;
      rstStart_r  <= ~resetSeen_r & cfg.rstDispEn;
    end
  end
  wire lowVolt    = (cfg.packVoltage <= cfg.termVoltage);
  wire chgActive  = cfg.chgDispEn & (cfg.packCurrent > cfg.chgDetectCurrent);
  wire pinAccept  = fallPulse & ~lock_r;
  wire startReq   = cfg.hostStart | rstStart_r | chgActive | pinAccept;
  wire failByEdge = pinAccept & cfg.failDispEn & cfg.failTrigSel;
  wire failByLong = longPulse & lock_r & cfg.failDispEn & ~cfg.failTrigSel;
  wire [2:0] lampTarget = (activeLamps > 3'(NUM_LAMPS)) ? 3'(NUM_LAMPS) : activeLamps;
  wire timerDone  = (timer_r == 32'h0000_0000);
  wire allLit     = (litCnt_r >= lampTarget);
  // ****************************************************************
  // display sequencer
  // ****************************************************************
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      LDACT_IDLE: if (startReq) state_nxt = LDACT_STEP;
      LDACT_STEP: if (allLit) state_nxt = LDACT_HOLD;
      LDACT_HOLD: if (timerDone && !chgActive) state_nxt = (failPend_r ? LDACT_FAIL : LDACT_IDLE);
      LDACT_FAIL: if (timerDone) state_nxt = LDACT_IDLE;
      default:    state_nxt = LDACT_IDLE;
    endcase
    if (lowVolt) state_nxt = LDACT_IDLE;
  end
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= LDACT_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end
  // step delay, hold and failure timers share one down counter
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      timer_r  <= 32'h0000_0000;
      litCnt_r <= 3'h0;
    end else if (state_nxt == LDACT_IDLE) begin
      timer_r  <= 32'h0000_0000;
      litCnt_r <= 3'h0;
    end else if (state_r == LDACT_STEP && state_nxt == LDACT_HOLD) begin
      timer_r <= 32'(HOLD_CYC - 1);
    end else if (state_r == LDACT_HOLD && state_nxt == LDACT_FAIL) begin
      timer_r <= 32'(LDACT_FAIL_MULT * HOLD_CYC - 1);
    end else if (state_r == LDACT_STEP && timerDone) begin
      litCnt_r <= litCnt_r + 3'h1;
      timer_r  <= 32'(STEP_CYC - 1);
    end else if (state_r == LDACT_HOLD && chgActive) begin
      timer_r <= 32'(HOLD_CYC - 1);
    end else if (!timerDone) begin
      timer_r <= timer_r - 32'h0000_0001;
    end
  end
  // pin lockout runs from an accepted edge until the hold time ends
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      lock_r     <= 1'b0;
      failPend_r <= 1'b0;
    end else begin
      if (pinAccept && !lowVolt) lock_r <= 1'b1;
      else if (state_nxt == LDACT_IDLE || state_nxt == LDACT_FAIL) lock_r <= 1'b0;
      if (state_nxt == LDACT_IDLE) failPend_r <= 1'b0;
      else if (failByEdge || failByLong) failPend_r <= 1'b1;
    end
  end
  // ****************************************************************
  // outputs
  // ****************************************************************
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      lampOn        <= '0;
      failDisplayOn <= 1'b0;
    end else begin
      for (int i = 0; i < NUM_LAMPS; i++) begin
        lampOn[i] <= (state_nxt == LDACT_STEP || state_nxt == LDACT_HOLD) && (3'(i) < litCnt_r);
      end
      failDisplayOn <= (state_nxt == LDACT_FAIL);
    end
  end
  assign fourthLampDischargeThreshold = LDACT_LAMP4_OFF_DEF;
  assign fifthLampDischargeThreshold  = LDACT_LAMP5_OFF_DEF;
  assign cfg.dispState  = state_r;
  assign cfg.dispActive = (state_r != LDACT_IDLE);
  assign cfg.lockout    = lock_r;
  // ****************************************************************
  // assertions
  // ****************************************************************
  AST_LOWVOLT_OFF: assert property (@(posedge clock) disable iff (!rst_b)
    lowVolt |=> (state_r == LDACT_IDLE)) else $error("display active at low voltage");
  // lockout must survive every cycle of the display until the hold count runs out
  AST_LOCK_IGNORE: assert property (@(posedge clock) disable iff (!rst_b)
    (lock_r && !lowVolt && (state_r == LDACT_STEP || (state_r == LDACT_HOLD && !timerDone))) |=> lock_r)
    else $error("lockout dropped before hold expired");
  AST_PIN_START: assert property (@(posedge clock) disable iff (!rst_b)
    (pinAccept && !lowVolt && state_r == LDACT_IDLE) |=> (state_r == LDACT_STEP))
    else $error("pin edge did not start display");
  AST_HOST_START: assert property (@(posedge clock) disable iff (!rst_b)
    (cfg.hostStart && !lowVolt && state_r == LDACT_IDLE) |=> (state_r == LDACT_STEP))
    else $error("host command did not start display");
  AST_FAIL_AFTER: assert property (@(posedge clock) disable iff (!rst_b)
    $rose(failDisplayOn) |-> ($past(state_r) == LDACT_HOLD) && failPend_r)
    else $error("failure display not after capacity display");
  // with select 0 a short press from idle must not arm the failure display
  AST_SEL0_NOEDGE: assert property (@(posedge clock) disable iff (!rst_b)
    (!cfg.failTrigSel && pinAccept && !longPulse && state_r == LDACT_IDLE && !lowVolt) |=> !failPend_r)
    else $error("edge trigger with select 0");
  AST_SEL1_EDGE: assert property (@(posedge clock) disable iff (!rst_b)
    (failByEdge && !lowVolt) |=> failPend_r) else $error("edge trigger lost with select 1");
  AST_CHG_HOLD: assert property (@(posedge clock) disable iff (!rst_b)
    (chgActive && state_r == LDACT_HOLD && !lowVolt) |=> (state_r == LDACT_HOLD))
    else $error("display left hold during charge");
  AST_ALL_OFF: assert property (@(posedge clock) disable iff (!rst_b)
    (state_r == LDACT_HOLD && state_nxt != LDACT_HOLD) |=> (lampOn == '0))
    else $error("lamps not all off after hold");
  AST_RESET_START: assert property (@(posedge clock) disable iff (!rst_b)
    (rstStart_r && !lowVolt && state_r == LDACT_IDLE) |=> (state_r == LDACT_STEP))
    else $error("reset exit did not start display");
endmodule : ldact_display

// File: dv/ldact_button.sv
// push-button model that drives the display request pin
`timescale 1ns/1ps
module ldact_button (
  // clock and reset
  input  wire logic       clock,
  input  wire logic       rst_b,
  // press command: hold the button down for pressLen cycles
  input  wire logic       pressGo,
  input  wire logic [7:0] pressLen,
  // request pin, pulled up while released
  output logic            pin
);
  logic [7:0] downCnt;
  // count the press down; a released button leaves the pin at the pull-up level
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b)
      downCnt <= 8'h00;
    else if (pressGo)
      downCnt <= pressLen;
    else if (downCnt != 8'h00)
      downCnt <= downCnt - 8'h01;
  end
  assign pin = (downCnt == 8'h00);
endmodule : ldact_button

// File: dv/led_gauge_display_activation_test.sv
// self-checking bench for the display activation block
`timescale 1ns/1ps
module led_gauge_display_activation_test;
  import ldact_pkg::*;
  localparam int HOLD = 40;
  typedef struct { logic [7:0] a; logic [31:0] d; logic [1:0] r; } ldact_row_t;
  logic        clock = 1'b0, rst_b = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00, pressLen = 8'h00;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0, pressGo = 1'b0;
  logic [31:0] wdata = 32'h0000_0000, rdata, rdVal;
  logic [3:0]  wstrb = 4'hF;
  logic [2:0]  activeLamps = 3'h3;
  logic        awready, wready, bvalid, arready, rvalid, displayRequestPin, failDisplayOn;
  logic [1:0]  bresp, rresp, rsVal;
  logic [4:0]  lampOn;
  logic [7:0]  fourthLampDischargeThreshold, fifthLampDischargeThreshold;
  int          fails = 0, compares = 0, cycles = 0, took;
  ldact_row_t  rows [6] = '{'{LDACT_ADDR_CTRL, 32'h1, LDACT_RESP_OKAY}, '{LDACT_ADDR_CURR, 32'h0, LDACT_RESP_OKAY},
    '{LDACT_ADDR_VOLT, 32'hFFFF, LDACT_RESP_OKAY}, '{LDACT_ADDR_THRESH, 32'h2328_0064, LDACT_RESP_OKAY},
    '{LDACT_ADDR_STATUS, 32'h0, LDACT_RESP_OKAY}, '{8'h18, 32'h0, LDACT_RESP_SLVERR}};
  ldact_display #(.HOLD_CYC(HOLD), .STEP_CYC(4), .LONG_CYC(20), .NUM_LAMPS(5)) u_dut (.clock, .rst_b,
    .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
    .arready, .rdata, .rresp, .rvalid, .rready, .displayRequestPin, .activeLamps, .lampOn, .failDisplayOn,
    .fourthLampDischargeThreshold, .fifthLampDischargeThreshold);
  ldact_button u_btn (.clock, .rst_b, .pressGo, .pressLen, .pin(displayRequestPin));
  // clock and hang guard
  always #2 clock = ~clock;
  always @(posedge clock) begin
    cycles++;
    if (cycles == 6000) begin
      fails++;
      conclude();
    end
  end
  task conclude;
    if (fails == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : conclude
  task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      $display("unexpected %s expected %h seen %h", name, exp, got);
      fails++;
    end
  endtask : chk
  // one bus access; ready sampled just before the rising edge, answer kept in rdVal and rsVal
  task axi(input bit wr, input logic [7:0] a, input logic [31:0] d);
    bit aw, w, ar, done;
    done = 1'b0;
    @(posedge clock);
    if (wr) begin
      awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    end else begin
      araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    end
    while (!done) begin
      @(negedge clock);
      aw = awvalid & awready; w = wvalid & wready; ar = arvalid & arready;
      done = wr ? bvalid : rvalid;
      rdVal = rdata; rsVal = wr ? bresp : rresp;
      @(posedge clock);
      if (aw) awvalid <= 1'b0;
      if (w) wvalid <= 1'b0;
      if (ar) arvalid <= 1'b0;
      if (done) begin
        bready <= 1'b0; rready <= 1'b0;
      end
    end
  endtask : axi
  // wait while a display output keeps value from, then compare its new value
  task waitChange(input string name, input bit isFail, input logic [4:0] from, input logic [4:0] exp, input int lim);
    logic [4:0] seen;
    took = 0;
    seen = from;
    while (seen === from && took < lim) begin
      @(negedge clock);
      seen = isFail ? {4'h0, failDisplayOn} : lampOn;
      took++;
    end
    chk(name, {27'h0, exp}, {27'h0, seen});
  endtask : waitChange
  task press(input logic [7:0] len);
    @(posedge clock);
    pressLen <= len; pressGo <= 1'b1;
    @(posedge clock);
    pressGo <= 1'b0;
  endtask : press
  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    repeat (20) @(posedge clock);
    rst_b <= 1'b1;
    // reset display is on after reset: the gauge lights by itself, then let it finish
    waitChange("reset lamp", 1'b0, 5'h00, 5'h01, 20);
    repeat (HOLD + 20) @(posedge clock);
    foreach (rows[i]) begin
      axi(1'b0, rows[i].a, 32'h0);
      chk("read data", rows[i].d, rdVal);
      chk("read resp", {30'h0, rows[i].r}, {30'h0, rsVal});
    end
    axi(1'b1, LDACT_ADDR_STATUS, 32'h1);
    chk("status write resp", {30'h0, LDACT_RESP_SLVERR}, {30'h0, rsVal});
    chk("fourth threshold", 32'h3C, {24'h0, fourthLampDischargeThreshold});
    chk("fifth threshold", 32'h50, {24'h0, fifthLampDischargeThreshold});
    // host start: lamps come one by one, hold, then all go off together
    axi(1'b1, LDACT_ADDR_CMD, 32'h1);
    waitChange("first lamp", 1'b0, 5'h00, 5'h01, 20);
    waitChange("second lamp", 1'b0, 5'h01, 5'h03, 8);
    waitChange("third lamp", 1'b0, 5'h03, 5'h07, 8);
    waitChange("all off", 1'b0, 5'h07, 5'h00, HOLD + 8);
    chk("hold length", 32'h1, {31'h0, took >= HOLD});
    chk("no failure display", 32'h0, {31'h0, failDisplayOn});
    // any-edge failure trigger, second press inside the display is ignored
    axi(1'b1, LDACT_ADDR_CTRL, 32'hC);
    press(8'h03);
    waitChange("pin lamp", 1'b0, 5'h00, 5'h01, 20);
    press(8'h03);
    axi(1'b0, LDACT_ADDR_STATUS, 32'h0);
    chk("lockout", 32'h1, {31'h0, rdVal[3]});
    waitChange("failure on", 1'b1, 5'h00, 5'h01, 200);
    chk("lamps off in failure", 32'h0, {27'h0, lampOn});
    waitChange("failure off", 1'b1, 5'h01, 5'h00, 3 * HOLD);
    chk("failure length", 32'h1, {31'h0, took >= 2 * HOLD - 2 && took <= 2 * HOLD + 2});
    waitChange("ignored edge", 1'b0, 5'h00, 5'h00, 20);
    // long-press trigger: short press gives none, long press gives failure display
    axi(1'b1, LDACT_ADDR_CTRL, 32'h4);
    press(8'h03);
    waitChange("short press", 1'b1, 5'h00, 5'h00, 150);
    press(8'h1E);
    waitChange("long press", 1'b1, 5'h00, 5'h01, 150);
    waitChange("long end", 1'b1, 5'h01, 5'h00, 3 * HOLD);
    // charge activity keeps the display up while current exceeds the threshold
    axi(1'b1, LDACT_ADDR_CTRL, 32'h2);
    axi(1'b1, LDACT_ADDR_CURR, 32'h65);
    waitChange("charge start", 1'b0, 5'h00, 5'h01, 20);
    // let the remaining lamps come up before watching the hold
    repeat (12) @(negedge clock);
    waitChange("charge hold", 1'b0, 5'h07, 5'h07, 3 * HOLD);
    axi(1'b1, LDACT_ADDR_CURR, 32'h64);
    waitChange("charge end", 1'b0, 5'h07, 5'h00, HOLD + 8);
    // voltage at terminate level blocks the host command and a pin press
    axi(1'b1, LDACT_ADDR_VOLT, 32'h2328);
    axi(1'b1, LDACT_ADDR_CMD, 32'h1);
    press(8'h03);
    waitChange("low voltage", 1'b0, 5'h00, 5'h00, 40);
    conclude();
  end
endmodule : led_gauge_display_activation_test
